// ### verilog/acfp_pkg.sv
/*
 * acfp_pkg: constants, opcode set and carriers for the accumulator,
 * status flag and instruction pointer core.
 * assumes: one 40 MHz clock domain, decoder issues one operation a cycle.
 */
package acfp_pkg;
    localparam int ACFP_DATA_W = 8;
    localparam int ACFP_PTR_W = 10;
    localparam int ACFP_HIGH_W = ACFP_PTR_W - ACFP_DATA_W;
    localparam int ACFP_ADDR_W = 8;

    // system register addresses
    localparam logic [7:0] ACFP_ADDR_FLAGS = 8'h86;
    localparam logic [7:0] ACFP_ADDR_LOW = 8'hce;
    localparam logic [7:0] ACFP_ADDR_HIGH = 8'hcf;

    // status_flag_reg bit positions
    localparam int ACFP_BIT_CAUSE_HI = 7;
    localparam int ACFP_BIT_CAUSE_LO = 6;
    localparam int ACFP_BIT_LV_HIGH = 5;
    localparam int ACFP_BIT_LV_MID = 4;
    localparam int ACFP_BIT_CARRY = 2;
    localparam int ACFP_BIT_HALF = 1;
    localparam int ACFP_BIT_ZERO = 0;

    // reset cause encodings
    localparam logic [1:0] ACFP_CAUSE_WDOG = 2'h0;
    localparam logic [1:0] ACFP_CAUSE_RSVD = 2'h1;
    localparam logic [1:0] ACFP_CAUSE_LVD = 2'h2;
    localparam logic [1:0] ACFP_CAUSE_PIN = 2'h3;

    // reset values and steps
    localparam logic [7:0] ACFP_ACC_RESET = 8'h00;
    localparam logic [9:0] ACFP_PTR_RESET = 10'h000;
    localparam logic [9:0] ACFP_STEP_ONE = 10'h001;
    localparam logic [9:0] ACFP_STEP_SKIP = 10'h002;
    localparam logic [7:0] ACFP_BYTE_ONE = 8'h01;
    localparam logic [7:0] ACFP_BYTE_ZERO = 8'h00;
    localparam logic [3:0] ACFP_NIB_ZERO = 4'h0;

    // operation set issued by the decoder
    typedef enum logic [4:0] {
        ACFP_OP_NOP = 5'h00,
        ACFP_OP_MOV = 5'h01, // move operand to destination
        ACFP_OP_ADD = 5'h02,
        ACFP_OP_ADC = 5'h03,
        ACFP_OP_SUB = 5'h04,
        ACFP_OP_SBC = 5'h05,
        ACFP_OP_AND = 5'h06,
        ACFP_OP_OR = 5'h07,
        ACFP_OP_XOR = 5'h08,
        ACFP_OP_RLC = 5'h09,
        ACFP_OP_RRC = 5'h0a,
        ACFP_OP_COMPARE_SKIP_OP = 5'h0b, // compare_skip_op
        ACFP_OP_INC_TO_ACC_SKIP = 5'h0c, // inc skip, result to accumulator
        ACFP_OP_INC_MEM_SKIP = 5'h0d, // inc skip, result to memory
        ACFP_OP_DEC_TO_ACC_SKIP = 5'h0e,
        ACFP_OP_DEC_MEM_SKIP = 5'h0f,
        ACFP_OP_BTCLR = 5'h10, // bit_clear_skip and bank0 form
        ACFP_OP_BTSET = 5'h11, // bit_set_skip and bank0 form
        ACFP_OP_JUMP = 5'h12,
        ACFP_OP_CALL = 5'h13,
        ACFP_OP_PUSH = 5'h14,
        ACFP_OP_POP = 5'h15
    } acfp_op_type;

    // where a result goes
    typedef enum logic [1:0] {
        ACFP_DST_ACC = 2'h0,
        ACFP_DST_MEM = 2'h1,
        ACFP_DST_LOW = 2'h2, // count_low_byte, computed jump
        ACFP_DST_NONE = 2'h3
    } acfp_dst_type;

    typedef struct packed {
        logic valid;
        acfp_op_type op;
        acfp_dst_type dst;
        logic [7:0] operand; // immediate or memory byte
        logic [2:0] bit_sel;
        logic [9:0] target; // jump or call destination
    } acfp_instr_type;

    typedef struct packed {
        logic cause_hi;
        logic cause_lo;
        logic lv_high;
        logic lv_mid;
        logic unused;
        logic carry;
        logic half;
        logic zero;
    } acfp_flags_type;
endpackage

// ### verilog/acfp_core.sv
/*
 * acfp_core: accumulator, status flags and 10-bit instruction pointer of
 * a small 8-bit controller, with the system register port for the flag
 * register and the two counter bytes.
 * assumes: decoder presents one operation per enabled cycle with its
 * memory operand already fetched; memory writes leave through mem_*.
 */
`timescale 1ns/1ps

module acfp_core
    import acfp_pkg::*;
#(
    parameter int DATA_W = ACFP_DATA_W,
    parameter int PTR_W = ACFP_PTR_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // reset source and supply monitor
    input wire logic [1:0] reset_source,
    input wire logic supply_le_high,
    input wire logic supply_le_mid,
    input wire logic undervolt_opt_high,
    input wire logic undervolt_opt_mid,
    // decoder side
    input wire acfp_instr_type instr,
    // system register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // fetch and memory side
    output logic [9:0] instr_pointer,
    output logic [7:0] work_accumulator,
    output acfp_flags_type status_flag_reg,
    output logic [7:0] mem_wdata,
    output logic mem_write,
    output logic call_push,
    output logic [9:0] call_return
);

    // elaboration check: the datapath is built for exactly these widths
    if (DATA_W != ACFP_DATA_W || PTR_W != ACFP_PTR_W)
    begin : g_width_check
        $error("acfp_core supports only 8-bit data and 10-bit pointer");
    end

    logic exec;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [7:0] result;
    logic next_carry;
    logic next_half;
    logic arith_flags;
    logic logic_flags;
    logic skip;
    logic [7:0] inc_val;
    logic [7:0] dec_val;
    logic [9:0] next_ptr;
    logic [9:0] low_sum;
    logic [7:0] save_acc;
    logic [7:0] save_flags;
    logic cause_pending;
    logic [7:0] flags_rd;

    assign exec = clk_en && instr.valid;
    assign inc_val = instr.operand + ACFP_BYTE_ONE;
    assign dec_val = instr.operand - ACFP_BYTE_ONE;

    // ALU: subtraction as a + ~b + 1 so carry out means no borrow
    always_comb
    begin
        sum9 = {1'b0, work_accumulator};
        nib5 = {1'b0, work_accumulator[3:0]};
        result = instr.operand;
        next_carry = status_flag_reg.carry;
        next_half = status_flag_reg.half;
        arith_flags = 1'b0;
        logic_flags = 1'b0;
        case (instr.op)
            ACFP_OP_ADD, ACFP_OP_ADC:
            begin
                sum9 = {1'b0, work_accumulator} + {1'b0, instr.operand}
                    + {8'h00, instr.op == ACFP_OP_ADC
                        && status_flag_reg.carry};
                nib5 = {1'b0, work_accumulator[3:0]}
                    + {1'b0, instr.operand[3:0]}
                    + {4'h0, instr.op == ACFP_OP_ADC
                        && status_flag_reg.carry};
                arith_flags = 1'b1;
            end
            ACFP_OP_SUB, ACFP_OP_SBC, ACFP_OP_COMPARE_SKIP_OP:
            begin
                // subtract without borrow in sets carry in first
                sum9 = {1'b0, work_accumulator} + {1'b0, ~instr.operand}
                    + {8'h00, instr.op != ACFP_OP_SBC
                        || status_flag_reg.carry};
                nib5 = {1'b0, work_accumulator[3:0]}
                    + {1'b0, ~instr.operand[3:0]}
                    + {4'h0, instr.op != ACFP_OP_SBC
                        || status_flag_reg.carry};
                arith_flags = 1'b1;
            end
            ACFP_OP_RLC:
                sum9 = {instr.operand, status_flag_reg.carry};
            ACFP_OP_RRC:
                sum9 = {instr.operand[0], status_flag_reg.carry,
                    instr.operand[7:1]};
            default:
                sum9 = {1'b0, work_accumulator};
        endcase
        case (instr.op)
            ACFP_OP_ADD, ACFP_OP_ADC, ACFP_OP_SUB, ACFP_OP_SBC,
            ACFP_OP_RLC, ACFP_OP_RRC, ACFP_OP_COMPARE_SKIP_OP:
            begin
                result = sum9[7:0];
                next_carry = sum9[8];
            end
            ACFP_OP_AND:
            begin
                result = work_accumulator & instr.operand;
                logic_flags = 1'b1;
            end
            ACFP_OP_OR:
            begin
                result = work_accumulator | instr.operand;
                logic_flags = 1'b1;
            end
            ACFP_OP_XOR:
            begin
                result = work_accumulator ^ instr.operand;
                logic_flags = 1'b1;
            end
            ACFP_OP_INC_TO_ACC_SKIP, ACFP_OP_INC_MEM_SKIP:
                result = inc_val;
            ACFP_OP_DEC_TO_ACC_SKIP, ACFP_OP_DEC_MEM_SKIP:
                result = dec_val;
            default:
                result = instr.operand;
        endcase
        if (arith_flags)
        begin
            next_half = nib5[4];
        end
    end

    // skip decision for the seven skipping instructions
    always_comb
    begin
        case (instr.op)
            ACFP_OP_COMPARE_SKIP_OP:
                skip = (work_accumulator == instr.operand);
            ACFP_OP_INC_TO_ACC_SKIP, ACFP_OP_INC_MEM_SKIP:
                skip = (inc_val == ACFP_BYTE_ZERO);
            ACFP_OP_DEC_TO_ACC_SKIP, ACFP_OP_DEC_MEM_SKIP:
                skip = (instr.operand == ACFP_BYTE_ONE);
            ACFP_OP_BTCLR:
                skip = !instr.operand[instr.bit_sel];
            ACFP_OP_BTSET:
                skip = instr.operand[instr.bit_sel];
            default:
                skip = 1'b0;
        endcase
    end

    // computed jump: add with carry into the high byte, plain write keeps it
    assign low_sum = {instr_pointer[9:8], ACFP_BYTE_ZERO}
        + {2'b00, result} + {1'b0, sum9[8], ACFP_BYTE_ZERO};

    always_comb
    begin
        next_ptr = instr_pointer + ACFP_STEP_ONE;
        if (instr.op == ACFP_OP_JUMP || instr.op == ACFP_OP_CALL)
        begin
            next_ptr = instr.target;
        end
        else if (skip)
        begin
            next_ptr = instr_pointer + ACFP_STEP_SKIP;
        end
        else if (instr.dst == ACFP_DST_LOW && instr.op != ACFP_OP_NOP)
        begin
            if (instr.op == ACFP_OP_ADD || instr.op == ACFP_OP_ADC)
            begin
                next_ptr = low_sum;
            end
            else
            begin
                next_ptr = {instr_pointer[9:8], result};
            end
        end
    end

    // instruction pointer; an executing instruction beats a port write
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            instr_pointer <= ACFP_PTR_RESET;
        end
        else if (exec)
        begin
            instr_pointer <= next_ptr;
        end
        else if (clk_en && reg_write && reg_addr == ACFP_ADDR_LOW)
        begin
            instr_pointer <= {instr_pointer[9:8], reg_wdata};
        end
        else if (clk_en && reg_write && reg_addr == ACFP_ADDR_HIGH)
        begin
            instr_pointer <= {reg_wdata[1:0], instr_pointer[7:0]};
        end
    end

    // accumulator: reached through its own destination code, or by pop from save_acc
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            work_accumulator <= ACFP_ACC_RESET;
        end
        else if (exec && instr.op == ACFP_OP_POP)
        begin
            work_accumulator <= save_acc;
        end
        else if (exec && instr.dst == ACFP_DST_ACC
            && instr.op != ACFP_OP_NOP && instr.op != ACFP_OP_COMPARE_SKIP_OP
            && instr.op != ACFP_OP_BTCLR && instr.op != ACFP_OP_BTSET
            && instr.op != ACFP_OP_JUMP && instr.op != ACFP_OP_CALL
            && instr.op != ACFP_OP_PUSH)
        begin
            work_accumulator <= result;
        end
    end

    // save buffers; interrupt entry has no path here at all
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            save_acc <= ACFP_BYTE_ZERO;
            save_flags <= ACFP_BYTE_ZERO;
        end
        else if (exec && instr.op == ACFP_OP_PUSH)
        begin
            save_acc <= work_accumulator;
            save_flags <= status_flag_reg;
        end
    end

    // alu flags; hardware update wins over a port write in the same cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_flag_reg.carry <= 1'b0;
            status_flag_reg.half <= 1'b0;
            status_flag_reg.zero <= 1'b0;
        end
        else if (exec && instr.op == ACFP_OP_POP)
        begin
            status_flag_reg.carry <= save_flags[ACFP_BIT_CARRY];
            status_flag_reg.half <= save_flags[ACFP_BIT_HALF];
            status_flag_reg.zero <= save_flags[ACFP_BIT_ZERO];
        end
        else if (exec && (arith_flags || logic_flags
            || instr.op == ACFP_OP_RLC || instr.op == ACFP_OP_RRC))
        begin
            status_flag_reg.carry <= next_carry;
            status_flag_reg.half <= next_half;
            status_flag_reg.zero <= (result == ACFP_BYTE_ZERO);
        end
        else if (clk_en && reg_write && reg_addr == ACFP_ADDR_FLAGS)
        begin
            status_flag_reg.carry <= reg_wdata[ACFP_BIT_CARRY];
            status_flag_reg.half <= reg_wdata[ACFP_BIT_HALF];
            status_flag_reg.zero <= reg_wdata[ACFP_BIT_ZERO];
        end
    end

    // reset cause: caught at the first enabled edge after release
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cause_pending <= 1'b1;
            status_flag_reg.cause_hi <= 1'b0;
            status_flag_reg.cause_lo <= 1'b0;
        end
        else if (clk_en && cause_pending)
        begin
            cause_pending <= 1'b0;
            status_flag_reg.cause_hi <= reset_source[1];
            status_flag_reg.cause_lo <= reset_source[0];
        end
        else if (clk_en && exec && instr.op == ACFP_OP_POP)
        begin
            status_flag_reg.cause_hi <= save_flags[ACFP_BIT_CAUSE_HI];
            status_flag_reg.cause_lo <= save_flags[ACFP_BIT_CAUSE_LO];
        end
        else if (clk_en && reg_write && reg_addr == ACFP_ADDR_FLAGS)
        begin
            status_flag_reg.cause_hi <= reg_wdata[ACFP_BIT_CAUSE_HI];
            status_flag_reg.cause_lo <= reg_wdata[ACFP_BIT_CAUSE_LO];
        end
    end

    // supply flags read-only, each only live under its own option
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_flag_reg.lv_high <= 1'b0;
            status_flag_reg.lv_mid <= 1'b0;
            status_flag_reg.unused <= 1'b0;
        end
        else if (clk_en)
        begin
            status_flag_reg.lv_high <= undervolt_opt_high
                && supply_le_high;
            status_flag_reg.lv_mid <= undervolt_opt_mid
                && supply_le_mid;
            status_flag_reg.unused <= 1'b0;
        end
    end

    // memory-destined results and call return address
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mem_wdata <= ACFP_BYTE_ZERO;
            mem_write <= 1'b0;
            call_push <= 1'b0;
            call_return <= ACFP_PTR_RESET;
        end
        else if (clk_en)
        begin
            mem_write <= exec && instr.dst == ACFP_DST_MEM
                && instr.op != ACFP_OP_NOP && instr.op != ACFP_OP_COMPARE_SKIP_OP
                && instr.op != ACFP_OP_BTCLR && instr.op != ACFP_OP_BTSET;
            mem_wdata <= result;
            call_push <= exec && instr.op == ACFP_OP_CALL;
            call_return <= instr_pointer + ACFP_STEP_ONE;
        end
    end

    // read data one cycle after the strobe; unmapped reads return zero
    assign flags_rd = status_flag_reg;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata <= ACFP_BYTE_ZERO;
        end
        else if (clk_en)
        begin
            reg_rdata <= ACFP_BYTE_ZERO;
            if (reg_read)
            begin
                case (reg_addr)
                    ACFP_ADDR_FLAGS:
                        reg_rdata <= flags_rd & 8'hf7;
                    ACFP_ADDR_LOW:
                        reg_rdata <= instr_pointer[7:0];
                    ACFP_ADDR_HIGH:
                        reg_rdata <= {6'h00, instr_pointer[9:8]};
                    default:
                        reg_rdata <= ACFP_BYTE_ZERO;
                endcase
            end
        end
    end

endmodule // acfp_core

// ### verif/acfp_core_checker.sv
/*
 * acfp_core_checker: concurrent checks on the ports of acfp_core.
 * assumes: bound into acfp_core, one clock, async active-low reset.
 */
`timescale 1ns/1ps

module acfp_core_checker
    import acfp_pkg::*;
#(
    parameter int DATA_W = ACFP_DATA_W,
    parameter int PTR_W = ACFP_PTR_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // supply monitor and straps
    input wire logic supply_le_high,
    input wire logic supply_le_mid,
    input wire logic undervolt_opt_high,
    input wire logic undervolt_opt_mid,
    // decoder and register port
    input wire acfp_instr_type instr,
    input wire logic reg_write,
    // core state
    input wire logic [9:0] instr_pointer,
    input wire logic [7:0] work_accumulator,
    input wire acfp_flags_type status_flag_reg,
    input wire logic call_push
);
    logic [8:0] add_sum;
    logic add_cy;
    logic [7:0] add_res;
    logic [9:0] tgt;
    logic [7:0] opd;
    logic [1:0] ptr_hi;

    // plain copies so that $past only ever sees whole signals
    assign add_sum = {1'b0, work_accumulator} + {1'b0, instr.operand};
    assign add_cy = add_sum[8];
    assign add_res = add_sum[7:0];
    assign tgt = instr.target;
    assign opd = instr.operand;
    assign ptr_hi = instr_pointer[9:8];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // taken operation; cycles with a racing port write are left out, though execution still owns the pointer
    sequence taken_s;
        instr.valid && clk_en && !reg_write;
    endsequence

    property skip_p(cond);
        taken_s ##0 cond |=> instr_pointer == $past(instr_pointer) + 10'h002;
    endproperty

    reset_ptr_a: assert property ($rose(resetn) |-> instr_pointer == 10'h000)
        else $error("pointer not cleared by reset");
    step_one_a: assert property (taken_s ##0 (instr.dst != ACFP_DST_LOW &&
        instr.op inside {ACFP_OP_ADD, ACFP_OP_SUB, ACFP_OP_AND})
        |=> instr_pointer == $past(instr_pointer) + 10'h001)
        else $error("pointer did not step by one");
    jump_load_a: assert property (taken_s ##0
        (instr.op inside {ACFP_OP_JUMP, ACFP_OP_CALL}) |=> instr_pointer == $past(tgt))
        else $error("jump target not loaded");
    call_push_a: assert property (taken_s ##0 instr.op == ACFP_OP_CALL |-> ##[1:2] call_push)
        else $error("call gave no push pulse");
    cmp_skip_a: assert property (skip_p(instr.op == ACFP_OP_COMPARE_SKIP_OP &&
        work_accumulator == instr.operand))
        else $error("compare equal did not skip");
    inc_skip_a: assert property (skip_p(instr.operand == 8'hff &&
        instr.op inside {ACFP_OP_INC_TO_ACC_SKIP, ACFP_OP_INC_MEM_SKIP}))
        else $error("increment wrap did not skip");
    dec_skip_a: assert property (skip_p(instr.operand == 8'h01 &&
        instr.op inside {ACFP_OP_DEC_TO_ACC_SKIP, ACFP_OP_DEC_MEM_SKIP}))
        else $error("decrement to zero did not skip");
    bit_skip_a: assert property (skip_p(
        (instr.op == ACFP_OP_BTCLR && !instr.operand[instr.bit_sel]) ||
        (instr.op == ACFP_OP_BTSET && instr.operand[instr.bit_sel])))
        else $error("bit test did not skip");
    low_write_a: assert property (taken_s ##0 (instr.op == ACFP_OP_MOV &&
        instr.dst == ACFP_DST_LOW) |=> instr_pointer == {$past(ptr_hi), $past(opd)})
        else $error("low byte write lost the high byte");
    add_flags_a: assert property (taken_s ##0 (instr.op == ACFP_OP_ADD &&
        instr.dst == ACFP_DST_ACC) |=> work_accumulator == $past(add_res) &&
        status_flag_reg.carry == $past(add_cy) &&
        status_flag_reg.zero == (work_accumulator == 8'h00))
        else $error("add result or flags wrong");
    lv_high_a: assert property ((supply_le_high && undervolt_opt_high) [*3]
        |-> status_flag_reg.lv_high)
        else $error("high supply flag not raised");
    lv_mid_a: assert property (!(supply_le_mid && undervolt_opt_mid) [*3]
        |-> !status_flag_reg.lv_mid)
        else $error("mid supply flag raised without cause");
    unused_bit_a: assert property (!status_flag_reg.unused)
        else $error("unused flag bit set");
endmodule // acfp_core_checker

bind acfp_core acfp_core_checker #(.DATA_W(DATA_W), .PTR_W(PTR_W)) u_chk (
    .clk, .resetn, .clk_en, .supply_le_high, .supply_le_mid,
    .undervolt_opt_high, .undervolt_opt_mid, .instr, .reg_write,
    .instr_pointer, .work_accumulator, .status_flag_reg, .call_push
);

// ### verif/acfp_fetch_model.sv
/*
 * acfp_fetch_model: decoder and fetch side, issues one operation a call.
 * assumes: caller waits for reset release before the first issue.
 */
`timescale 1ns/1ps

module acfp_fetch_model
    import acfp_pkg::*;
(
    // clock
    input wire logic clk,
    // decoder side of the core
    output acfp_instr_type instr
);
    initial instr = '0;

    // lag idles first; stale fields are inverted so nothing reads as held
    task automatic issue(input acfp_op_type op, input acfp_dst_type dst,
        input logic [7:0] opd, input logic [9:0] tgt, input int lag);
        begin
            repeat (lag) @(posedge clk);
            @(posedge clk);
            instr <= '{1'b1, op, dst, opd, 3'h3, tgt};
            @(posedge clk);
            instr <= '{1'b0, ACFP_OP_NOP, ACFP_DST_NONE, ~opd, 3'h4, ~tgt};
        end
    endtask
endmodule // acfp_fetch_model

// ### verif/testbench.sv
/*
 * testbench: sequences of register and instruction calls on acfp_core.
 * assumes: 40 MHz clock, clk_en held high, fetch model drives instr.
 */
`timescale 1ns/1ps

module testbench;
    import acfp_pkg::*;
    logic clk, resetn, clk_en, supply_le_high, supply_le_mid;
    logic undervolt_opt_high, undervolt_opt_mid, reg_write, reg_read;
    logic [1:0] reset_source;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, work_accumulator, mem_wdata;
    logic [9:0] instr_pointer, call_return, ep;
    logic call_push, mem_write;
    acfp_instr_type instr;
    acfp_flags_type status_flag_reg;
    int fails = 0;
    int comparisons = 0;
    int i;
    acfp_op_type sk_op [15] = '{ACFP_OP_MOV, ACFP_OP_COMPARE_SKIP_OP, ACFP_OP_COMPARE_SKIP_OP,
        ACFP_OP_INC_TO_ACC_SKIP, ACFP_OP_INC_TO_ACC_SKIP, ACFP_OP_INC_MEM_SKIP, ACFP_OP_INC_MEM_SKIP,
        ACFP_OP_DEC_TO_ACC_SKIP, ACFP_OP_DEC_TO_ACC_SKIP, ACFP_OP_DEC_MEM_SKIP, ACFP_OP_DEC_MEM_SKIP,
        ACFP_OP_BTCLR, ACFP_OP_BTCLR, ACFP_OP_BTSET, ACFP_OP_BTSET};
    logic [7:0] sk_opd [15] = '{8'h12, 8'h12, 8'h13, 8'hff, 8'h10, 8'hff,
        8'h10, 8'h01, 8'h02, 8'h01, 8'h02, 8'hf7, 8'h08, 8'h08, 8'hf7};

    acfp_core u_dut (.clk, .resetn, .clk_en, .reset_source, .supply_le_high,
        .supply_le_mid, .undervolt_opt_high, .undervolt_opt_mid, .instr,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .instr_pointer, .work_accumulator, .status_flag_reg, .mem_wdata,
        .mem_write, .call_push, .call_return);
    acfp_fetch_model u_fetch (.clk, .instr);

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic stop_test;
        begin
            $display("comparisons=%0d fails=%0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    task automatic chk(input logic [9:0] got, input logic [9:0] exp_v,
        input string msg);
        begin
            comparisons++;
            if (got !== exp_v)
            begin
                fails++;
                $display("CHECK FAILED t=%0t %s", $time, msg);
            end
        end
    endtask

    // one operation, then settle past the edge that takes it
    task automatic ex(input acfp_op_type op, input acfp_dst_type dst,
        input logic [7:0] opd, input logic [9:0] tgt, input int lag);
        begin
            u_fetch.issue(op, dst, opd, tgt, lag);
            #1;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_write <= 1'b1;
            @(posedge clk);
            reg_write <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp_v);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_read <= 1'b1;
            @(posedge clk);
            reg_read <= 1'b0;
            #1;
            chk(reg_rdata, exp_v, "register read");
        end
    endtask

    task automatic do_reset(input logic [1:0] cause);
        begin
            resetn <= 1'b0;
            reset_source <= cause;
            repeat (20) @(posedge clk);
            resetn <= 1'b1;
            repeat (2) @(posedge clk);
            #1;
            chk(instr_pointer, 10'h000, "pointer after reset");
            chk(status_flag_reg[7:6], cause, "reset cause");
        end
    endtask

    // cut a hang short well past the expected two hundred or fewer cycles
    initial
    begin
        repeat (4000) @(posedge clk);
        fails++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        stop_test;
    end

    initial
    begin
        {clk_en, resetn, supply_le_high, supply_le_mid} = 4'h8;
        {undervolt_opt_high, undervolt_opt_mid, reg_write, reg_read} = 4'h0;
        {reg_addr, reg_wdata, reset_source} = '0;
        do_reset(ACFP_CAUSE_PIN);
        // arithmetic results and flags
        ex(ACFP_OP_MOV, ACFP_DST_ACC, 8'hff, 10'h0, 0);
        ex(ACFP_OP_ADD, ACFP_DST_ACC, 8'h01, 10'h0, 0);
        chk(work_accumulator, 8'h00, "add wrap");
        chk(status_flag_reg[2:0], 3'h7, "add flags");
        chk(instr_pointer, 10'h002, "step one");
        ex(ACFP_OP_MOV, ACFP_DST_ACC, 8'h10, 10'h0, 0);
        ex(ACFP_OP_SUB, ACFP_DST_ACC, 8'h20, 10'h0, 0);
        chk(work_accumulator, 8'hf0, "sub borrow");
        chk(status_flag_reg[2:0] & 3'h5, 3'h0, "borrow flags");
        ex(ACFP_OP_SUB, ACFP_DST_ACC, 8'h10, 10'h0, 0);
        chk(status_flag_reg[2:0], 3'h6, "sub no borrow");
        ex(ACFP_OP_MOV, ACFP_DST_ACC, 8'h0f, 10'h0, 0);
        ex(ACFP_OP_ADD, ACFP_DST_ACC, 8'h01, 10'h0, 0);
        chk(status_flag_reg[2:0], 3'h2, "nibble carry");
        ex(ACFP_OP_MOV, ACFP_DST_ACC, 8'h80, 10'h0, 0);
        ex(ACFP_OP_RLC, ACFP_DST_ACC, 8'h80, 10'h0, 0);
        chk(status_flag_reg[2], 1'b1, "rotate out one");
        ex(ACFP_OP_AND, ACFP_DST_ACC, 8'h00, 10'h0, 0);
        chk(status_flag_reg[0], 1'b1, "logic zero");
        // jump and call, the call presented late
        ex(ACFP_OP_JUMP, ACFP_DST_NONE, 8'h00, 10'h3a5, 0);
        chk(instr_pointer, 10'h3a5, "jump");
        ex(ACFP_OP_CALL, ACFP_DST_NONE, 8'h00, 10'h123, 2);
        chk(instr_pointer, 10'h123, "call");
        chk(call_push, 1'b1, "call push");
        chk(call_return, 10'h3a6, "call return");
        // every skip form, taken and not taken
        ex(ACFP_OP_JUMP, ACFP_DST_NONE, 8'h00, 10'h100, 0);
        ep = 10'h100;
        for (i = 0; i < 15; i++)
        begin
            ex(sk_op[i], acfp_dst_type'(i == 0 ? ACFP_DST_ACC : ACFP_DST_MEM),
                sk_opd[i], 10'h0, 0);
            ep = ep + (i[0] ? 10'h002 : 10'h001);
            chk(instr_pointer, ep, "skip step");
        end
        ex(ACFP_OP_DEC_MEM_SKIP, ACFP_DST_MEM, 8'h40, 10'h0, 0);
        chk({mem_write, mem_wdata}, 9'h13f, "mem result");
        // computed jumps through the low byte
        ex(ACFP_OP_JUMP, ACFP_DST_NONE, 8'h00, 10'h123, 0);
        ex(ACFP_OP_MOV, ACFP_DST_ACC, 8'hf0, 10'h0, 0);
        ex(ACFP_OP_ADD, ACFP_DST_LOW, 8'h24, 10'h0, 0);
        chk(instr_pointer, 10'h214, "low add carry");
        ex(ACFP_OP_MOV, ACFP_DST_LOW, 8'h28, 10'h0, 0);
        chk(instr_pointer, 10'h228, "low write");
        rd(ACFP_ADDR_LOW, 8'h28);
        rd(ACFP_ADDR_HIGH, 8'h02);
        rd(8'h55, 8'h00);
        // read-only bits hold; save and restore of accumulator and flags
        ex(ACFP_OP_MOV, ACFP_DST_ACC, 8'h5a, 10'h0, 0);
        wr(ACFP_ADDR_FLAGS, 8'hbd);
        rd(ACFP_ADDR_FLAGS, 8'h85);
        ex(ACFP_OP_PUSH, ACFP_DST_NONE, 8'h00, 10'h0, 0);
        ex(ACFP_OP_MOV, ACFP_DST_ACC, 8'h00, 10'h0, 0);
        wr(ACFP_ADDR_FLAGS, 8'h00);
        ex(ACFP_OP_POP, ACFP_DST_NONE, 8'h00, 10'h0, 0);
        chk(work_accumulator, 8'h5a, "pop accumulator");
        rd(ACFP_ADDR_FLAGS, 8'h85);
        // supply flags against their option straps
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk);
            supply_le_high <= i[0];
            undervolt_opt_high <= i[1];
            supply_le_mid <= i[0];
            undervolt_opt_mid <= i[1];
            repeat (3) @(posedge clk);
            #1;
            chk(status_flag_reg[5], i[0] & i[1], "high supply flag");
            chk(status_flag_reg[4], i[0] & i[1], "mid supply flag");
        end
        // reset in mid-run with the other causes
        do_reset(ACFP_CAUSE_WDOG);
        do_reset(ACFP_CAUSE_LVD);
        stop_test;
    end
endmodule // testbench
